// ===== core/rstc_core.sv
// Sync pattern, transmit turnaround and analogue trim register bank on APB
// Function
// [R1] Sync pattern: two bytes, reset a7 and 0f
// [R2] Nibbles used least significant first, both directions
// [R3] Transmit sends all-ones nibble as zero
// [R4] Receive ignores all-ones pattern nibbles
// [R5] Receive needs zero before first required nibble
// [R6] Turnaround 8 or 12 symbols, select resets 1
// [R7] One bit selects single-ended or differential amplifier
// [R8] Three-bit amplifier bias trim, reset 011
// [R9] Five-bit output level, reset 1f
// [R10] Three two-bit transmit mixer fields as outputs
// [R11] Three two-bit receive fields, documented resets
// [R12] Receive register top bits read zero
// [R13] Turnaround counted in 16 us symbols
`timescale 1ns/1ns
`default_nettype none
module rstc_core #(
  parameter int SYM_CYC = rstc_pkg::SYM_CYC
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [rstc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [rstc_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [rstc_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        transmit_on_strobe,
  output logic                             tx_busy,
  output logic      [3:0]                  tx_sym,
  output logic                             tx_sym_valid,
  output logic                             tx_sync_done,
  input  wire logic [3:0]                  rx_sym,
  input  wire logic                        rx_sym_valid,
  output logic                             rx_sync_found,
  output logic      [15:0]                 frame_sync_pattern,
  output logic                             tx_start_delay_select,
  output logic      [1:0]                  tx_mix_buffer_bias,
  output logic      [1:0]                  tx_mixer_varactor_sel,
  output logic      [1:0]                  tx_mixer_bias,
  output logic                             amp_output_differential,
  output logic      [2:0]                  amp_bias_trim,
  output logic      [4:0]                  amp_output_level,
  output logic      [1:0]                  rx_mix_buffer_bias,
  output logic      [1:0]                  lownoise_comp_high,
  output logic      [1:0]                  lownoise_comp_medium
);
  import rstc_pkg::*;

  typedef struct packed {
    logic [7:0]  sync_hi;
    logic [7:0]  sync_lo;
    logic [7:0]  tx_hi;
    logic [7:0]  tx_lo;
    logic [7:0]  rx0_hi;
    logic [7:0]  rdata;
    logic        rerr;
    rstc_tx_e    tx_st;
    logic [3:0]  sym_cnt;
    logic [3:0]  sym_target;
    logic [1:0]  nib_idx;
    logic [3:0]  tx_sym;
    logic        tx_vld;
    logic        tx_done;
    logic [19:0] hist;
    logic [4:0]  hist_vld;
    logic        found;
  } rstc_core_s;

  localparam rstc_core_s RST_STATE = '{
    sync_hi:    RST_SYNC_HI,
    sync_lo:    RST_SYNC_LO,
    tx_hi:      RST_TX_HI,
    tx_lo:      RST_TX_LO,
    rx0_hi:     RST_RX0_HI,
    rdata:      8'h00,
    rerr:       1'b0,
    tx_st:      TX_IDLE,
    sym_cnt:    4'h0,
    sym_target: 4'h0,
    nib_idx:    2'h0,
    tx_sym:     4'h0,
    tx_vld:     1'b0,
    tx_done:    1'b0,
    hist:       20'h00000,
    hist_vld:   5'h00,
    found:      1'b0
  };

  rstc_core_s s_q;
  rstc_core_s s_d;
  logic       sym_tick;
  logic       timer_restart;
  logic [15:0] pattern;

  assign pattern = {s_q.sync_hi, s_q.sync_lo};

  // Transmit symbol for nibble i; all-ones is replaced by zero
  function automatic logic [3:0] tx_nibble(input logic [15:0] pat, input logic [1:0] idx);
    logic [3:0] nib;
    nib = pat[4*idx +: 4];
    return (nib == NIB_SKIP) ? NIB_ZERO : nib; // [R3]
  endfunction : tx_nibble

  // Match on history h (entry 0 newest); nibble i arrived 3-i symbols ago
  function automatic logic sync_match(input logic [15:0] pat, input logic [19:0] h, input logic [4:0] hv);
    int   first;
    logic ok;
    first = 4;
    ok    = 1'b1;
    for (int i = 3; i >= 0; i--) begin
      if (pat[4*i +: 4] != NIB_SKIP) begin
        first = i;
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (pat[4*i +: 4] != NIB_SKIP) begin // [R4]
        ok = ok && hv[3-i] && (h[4*(3-i) +: 4] == pat[4*i +: 4]); // [R2]
      end
    end
    ok = ok && hv[4-first] && (h[4*(4-first) +: 4] == NIB_ZERO); // [R5]
    return ok;
  endfunction : sync_match

  // Phase restarts on the accepting cycle so the wait is whole symbols
  assign timer_restart = (s_q.tx_st == TX_IDLE) && transmit_on_strobe; // [R13]

  rstc_sym_timer #(
    .SYM_CYC (SYM_CYC)
  ) u_sym_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .restart  (timer_restart),
    .run      (timer_restart || (s_q.tx_st != TX_IDLE)),
    .sym_tick (sym_tick)
  );

  always_comb begin
    s_d         = s_q;
    s_d.tx_vld  = 1'b0;
    s_d.tx_done = 1'b0;
    s_d.found   = 1'b0;

    // Read data and error captured in setup, shown in the access cycle
    if (psel && !penable) begin
      s_d.rerr  = 1'b0;
      s_d.rdata = 8'h00;
      case (paddr)
        ADDR_SYNC_HI: s_d.rdata = s_q.sync_hi; // [R1]
        ADDR_SYNC_LO: s_d.rdata = s_q.sync_lo; // [R1]
        ADDR_TX_HI:   s_d.rdata = s_q.tx_hi;
        ADDR_TX_LO:   s_d.rdata = s_q.tx_lo;
        ADDR_RX0_HI:  s_d.rdata = s_q.rx0_hi & RX0_WMASK; // [R12]
        default:      s_d.rerr  = 1'b1;
      endcase
    end

    // Only the low byte lane carries register bits
    if (psel && penable && pwrite && pstrb[0]) begin
      case (paddr)
        ADDR_SYNC_HI: s_d.sync_hi = pwdata[7:0]; // [R1]
        ADDR_SYNC_LO: s_d.sync_lo = pwdata[7:0]; // [R1]
        ADDR_TX_HI:   s_d.tx_hi   = pwdata[7:0]; // [R10]
        ADDR_TX_LO:   s_d.tx_lo   = pwdata[7:0]; // [R9]
        ADDR_RX0_HI:  s_d.rx0_hi  = pwdata[7:0] & RX0_WMASK; // [R12]
        default:      s_d.rerr    = s_q.rerr;
      endcase
    end

    // Strobes while busy are dropped, not queued
    unique case (s_q.tx_st)
      TX_IDLE: begin
        if (transmit_on_strobe) begin
          s_d.tx_st   = TX_WAIT;
          s_d.sym_cnt = 4'h0;
          // Select sampled at the strobe; later writes do not stretch this wait
          s_d.sym_target = s_q.tx_hi[TXH_TURN_BIT] ? 4'(TURN_LONG_SYM) : 4'(TURN_SHORT_SYM); // [R6]
        end
      end
      TX_WAIT: begin
        if (sym_tick) begin
          s_d.sym_cnt = s_q.sym_cnt + 4'h1; // [R13]
          if (s_q.sym_cnt + 4'h1 == s_q.sym_target) begin // [R6]
            s_d.tx_st   = TX_SYNC;
            s_d.nib_idx = 2'h0;
            s_d.tx_sym  = tx_nibble(pattern, 2'h0); // [R2]
            s_d.tx_vld  = 1'b1;
          end
        end
      end
      TX_SYNC: begin
        if (sym_tick) begin
          if (s_q.nib_idx == 2'h3) begin
            s_d.tx_st   = TX_IDLE;
            s_d.tx_done = 1'b1;
          end else begin
            s_d.nib_idx = s_q.nib_idx + 2'h1; // [R2]
            s_d.tx_sym  = tx_nibble(pattern, s_q.nib_idx + 2'h1); // [R3]
            s_d.tx_vld  = 1'b1;
          end
        end
      end
    endcase

    // Sliding five-symbol window for the search
    if (rx_sym_valid) begin
      s_d.hist     = {s_q.hist[15:0], rx_sym};
      s_d.hist_vld = {s_q.hist_vld[3:0], 1'b1};
      s_d.found    = sync_match(pattern, s_d.hist, s_d.hist_vld); // [R4]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata       = {24'h000000, s_q.rdata};
  assign pready       = 1'b1;
  assign pslverr      = s_q.rerr & psel & penable;
  assign tx_busy      = (s_q.tx_st != TX_IDLE);
  assign tx_sym       = s_q.tx_sym;
  assign tx_sym_valid = s_q.tx_vld;
  assign tx_sync_done = s_q.tx_done;
  assign rx_sync_found = s_q.found;

  assign frame_sync_pattern      = pattern; // [R1]
  assign tx_start_delay_select   = s_q.tx_hi[TXH_TURN_BIT]; // [R6]
  assign tx_mix_buffer_bias      = s_q.tx_hi[TXH_BUFB_LSB +: 2]; // [R10]
  assign tx_mixer_varactor_sel   = s_q.tx_hi[TXH_VAR_LSB +: 2]; // [R10]
  assign tx_mixer_bias           = s_q.tx_hi[TXH_MIX_LSB +: 2]; // [R10]
  assign amp_output_differential = s_q.tx_hi[TXH_DIFF_BIT]; // [R7]
  assign amp_bias_trim           = s_q.tx_lo[TXL_TRIM_LSB +: 3]; // [R8]
  assign amp_output_level        = s_q.tx_lo[TXL_LEVEL_LSB +: 5]; // [R9]
  assign rx_mix_buffer_bias      = s_q.rx0_hi[RX0_BUFB_LSB +: 2]; // [R11]
  assign lownoise_comp_high      = s_q.rx0_hi[RX0_HIGH_LSB +: 2]; // [R11]
  assign lownoise_comp_medium    = s_q.rx0_hi[RX0_MED_LSB +: 2]; // [R11]

endmodule : rstc_core
`default_nettype wire

// ===== core/rstc_pkg.sv
// Constants and types shared by the radio sync and transmit configuration block
package rstc_pkg;

  // Bus geometry; printed offsets are word indices, byte address is index times four
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam logic [15:0] IDX_SYNC_HI = 16'hdf08;
  localparam logic [15:0] IDX_SYNC_LO = 16'hdf09;
  localparam logic [15:0] IDX_TX_HI   = 16'hdf0a;
  localparam logic [15:0] IDX_TX_LO   = 16'hdf0b;
  localparam logic [15:0] IDX_RX0_HI  = 16'hdf0c;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_HI = {IDX_SYNC_HI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SYNC_LO = {IDX_SYNC_LO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TX_HI   = {IDX_TX_HI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TX_LO   = {IDX_TX_LO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RX0_HI  = {IDX_RX0_HI, 2'b00};

  // Reset values
  localparam logic [7:0] RST_SYNC_HI = 8'ha7;
  localparam logic [7:0] RST_SYNC_LO = 8'h0f;
  localparam logic [7:0] RST_TX_HI   = 8'ha1;
  localparam logic [7:0] RST_TX_LO   = 8'h7f;
  localparam logic [7:0] RST_RX0_HI  = 8'h12;

  // Field positions
  localparam int TXH_BUFB_LSB  = 6;
  localparam int TXH_TURN_BIT  = 5;
  localparam int TXH_VAR_LSB   = 3;
  localparam int TXH_MIX_LSB   = 1;
  localparam int TXH_DIFF_BIT  = 0;
  localparam int TXL_TRIM_LSB  = 5;
  localparam int TXL_LEVEL_LSB = 0;
  localparam int RX0_BUFB_LSB  = 4;
  localparam int RX0_HIGH_LSB  = 2;
  localparam int RX0_MED_LSB   = 0;
  localparam logic [7:0] RX0_WMASK = 8'h3f;

  // Symbol nibble codes
  localparam logic [3:0] NIB_SKIP = 4'hf;
  localparam logic [3:0] NIB_ZERO = 4'h0;

  // Timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int SYMBOL_NS      = 16000;
  localparam int SYM_CYC        = SYMBOL_NS / CLK_PERIOD_NS;
  localparam int TURN_SHORT_US  = 128;
  localparam int TURN_LONG_US   = 192;
  localparam int TURN_SHORT_SYM = TURN_SHORT_US * 1000 / SYMBOL_NS;
  localparam int TURN_LONG_SYM  = TURN_LONG_US * 1000 / SYMBOL_NS;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_WAIT,
    TX_SYNC
  } rstc_tx_e;

endpackage : rstc_pkg

// ===== core/rstc_sym_timer.sv
// Symbol period divider that yields a one-cycle tick every symbol
`timescale 1ns/1ns
`default_nettype none
module rstc_sym_timer #(
  parameter int SYM_CYC = 400
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic restart,
  input  wire logic run,
  output logic      sym_tick
);
  import rstc_pkg::*;

  localparam int CW = $clog2(SYM_CYC);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } rstc_tim_s;

  rstc_tim_s s_q;
  rstc_tim_s s_d;

  assign sym_tick = run && (s_q.cnt == CW'(SYM_CYC - 1));

  always_comb begin
    s_d = s_q;
    // Restart aligns the phase to the accepting cycle
    if (restart || !run || sym_tick) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : rstc_sym_timer
`default_nettype wire

// ===== verif/rstc_core_assertions.sv
// Checker bound to the sync and transmit configuration bank
`timescale 1ns/1ns
`default_nettype none
module rstc_core_assertions
  import rstc_pkg::*;
#(
  parameter int SYM_CYC = 400
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [rstc_pkg::ADDR_W-1:0] paddr,
  input wire logic [rstc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [rstc_pkg::DATA_W-1:0] prdata,
  input wire logic                        transmit_on_strobe,
  input wire logic                        tx_busy,
  input wire logic [3:0]                  tx_sym,
  input wire logic                        tx_sym_valid,
  input wire logic                        tx_sync_done,
  input wire logic [3:0]                  rx_sym,
  input wire logic                        rx_sym_valid,
  input wire logic                        rx_sync_found,
  input wire logic [15:0]                 frame_sync_pattern,
  input wire logic                        tx_start_delay_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] cnt_q;
  logic [15:0] first_q;
  int          off;
  assign off = int'(cnt_q - first_q);
  // Frame-relative count; a counter avoids delays far beyond tool limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= '0;
      first_q <= '0;
    end else if (transmit_on_strobe && !tx_busy) begin
      cnt_q   <= 16'h0001;
      first_q <= 16'((tx_start_delay_select ? 12 : 8) * SYM_CYC + 1);
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  function automatic logic [3:0] nib(input logic [15:0] p, input int i);
    return (p[4*i+:4] == 4'hf) ? 4'h0 : p[4*i+:4];
  endfunction : nib
  sequence s_wr_lo;
    psel && penable && pwrite && pstrb[0] && paddr == ADDR_SYNC_LO;
  endsequence
  sequence s_start;
    transmit_on_strobe && !tx_busy;
  endsequence
  a_rx0_top_zero: assert property (psel && penable && !pwrite && paddr == ADDR_RX0_HI |-> prdata[31:6] == '0)
    else $error("rx0 reserved bits read nonzero");
  a_sync_lo_write: assert property (s_wr_lo |=> frame_sync_pattern[7:0] == $past(pwdata[7:0]))
    else $error("sync low byte not written");
  a_busy_start: assert property (s_start |=> tx_busy [*2])
    else $error("busy missing after strobe");
  a_sym_timing: assert property (tx_sym_valid |-> cnt_q >= first_q && off % SYM_CYC == 0 && off < 4 * SYM_CYC)
    else $error("symbol pulse off its slot");
  a_sym_nibble: assert property (tx_sym_valid |-> tx_sym == nib(frame_sync_pattern, off / SYM_CYC))
    else $error("wrong sync nibble sent");
  a_no_ones_sent: assert property (tx_sym_valid |-> tx_sym != 4'hf)
    else $error("all-ones nibble sent");
  a_done_timing: assert property (tx_sync_done |-> !tx_busy && off == 4 * SYM_CYC)
    else $error("sync end off its slot");
  // A skipped top nibble lets any last symbol complete the match, except a zero is needed when all four nibbles are skipped
  a_rx_match_end: assert property (rx_sync_found |-> $past(rx_sym_valid) &&
    ($past(frame_sync_pattern[15:12]) == 4'hf || $past(rx_sym) == $past(frame_sync_pattern[15:12])))
    else $error("sync found without the last pattern symbol");
endmodule : rstc_core_assertions
bind rstc_core rstc_core_assertions #(
  .SYM_CYC (SYM_CYC)
) u_chk (
  .pclk                  (pclk),
  .presetn               (presetn),
  .psel                  (psel),
  .penable               (penable),
  .pwrite                (pwrite),
  .paddr                 (paddr),
  .pwdata                (pwdata),
  .pstrb                 (pstrb),
  .prdata                (prdata),
  .transmit_on_strobe    (transmit_on_strobe),
  .tx_busy               (tx_busy),
  .tx_sym                (tx_sym),
  .tx_sym_valid          (tx_sym_valid),
  .tx_sync_done          (tx_sync_done),
  .rx_sym                (rx_sym),
  .rx_sym_valid          (rx_sym_valid),
  .rx_sync_found         (rx_sync_found),
  .frame_sync_pattern    (frame_sync_pattern),
  .tx_start_delay_select (tx_start_delay_select)
);
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the sync and transmit configuration bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
  import rstc_pkg::*;
  localparam int S = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, tx_start_delay_select;
  logic        transmit_on_strobe, tx_busy, tx_sym_valid, tx_sync_done, rx_sym_valid, rx_sync_found;
  logic        amp_output_differential;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, tx_sym, rx_sym;
  logic [15:0] frame_sync_pattern;
  logic [1:0]  tx_mix_buffer_bias, tx_mixer_varactor_sel, tx_mixer_bias;
  logic [1:0]  rx_mix_buffer_bias, lownoise_comp_high, lownoise_comp_medium;
  logic [2:0]  amp_bias_trim;
  logic [4:0]  amp_output_level;
  int          failures, checks_done, cycles;
  wire  [7:0]  txf = {tx_mix_buffer_bias, tx_start_delay_select, tx_mixer_varactor_sel, tx_mixer_bias,
                      amp_output_differential};
  wire  [7:0]  ampf = {amp_bias_trim, amp_output_level};
  wire  [5:0]  rxf = {rx_mix_buffer_bias, lownoise_comp_high, lownoise_comp_medium};
  rstc_core #(
    .SYM_CYC (S)
  ) uut (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .pstrb                   (pstrb),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .transmit_on_strobe      (transmit_on_strobe),
    .tx_busy                 (tx_busy),
    .tx_sym                  (tx_sym),
    .tx_sym_valid            (tx_sym_valid),
    .tx_sync_done            (tx_sync_done),
    .rx_sym                  (rx_sym),
    .rx_sym_valid            (rx_sym_valid),
    .rx_sync_found           (rx_sync_found),
    .frame_sync_pattern      (frame_sync_pattern),
    .tx_start_delay_select   (tx_start_delay_select),
    .tx_mix_buffer_bias      (tx_mix_buffer_bias),
    .tx_mixer_varactor_sel   (tx_mixer_varactor_sel),
    .tx_mixer_bias           (tx_mixer_bias),
    .amp_output_differential (amp_output_differential),
    .amp_bias_trim           (amp_bias_trim),
    .amp_output_level        (amp_output_level),
    .rx_mix_buffer_bias      (rx_mix_buffer_bias),
    .lownoise_comp_high      (lownoise_comp_high),
    .lownoise_comp_medium    (lownoise_comp_medium)
  );
  always #20 pclk = ~pclk;
  // Whole run takes well under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles > 5000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [17:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK("prdata", {24'h0, e}, rd)
  endtask : rdchk
  task automatic t_reset();
    rdchk(ADDR_SYNC_HI, 8'ha7);
    rdchk(ADDR_SYNC_LO, 8'h0f);
    rdchk(ADDR_TX_HI, 8'ha1);
    rdchk(ADDR_TX_LO, 8'h7f);
    rdchk(ADDR_RX0_HI, 8'h12);
    `CHK("txf", 8'ha1, txf)
    `CHK("ampf", 8'h7f, ampf)
    `CHK("rxf", 6'h12, rxf)
    `CHK("pattern", 16'ha70f, frame_sync_pattern)
    apb(1'b0, 18'h00100, 8'h00);
    `CHK("unmapped", 1'b1, err)
  endtask : t_reset
  task automatic t_write();
    apb(1'b1, ADDR_RX0_HI, 8'hff);
    rdchk(ADDR_RX0_HI, 8'h3f);
    `CHK("rxf", 6'h3f, rxf)
    apb(1'b1, ADDR_TX_LO, 8'h4a);
    pstrb <= 4'h0;
    apb(1'b1, ADDR_TX_LO, 8'h00);
    pstrb <= 4'hf;
    `CHK("ampf", 8'h4a, ampf)
    apb(1'b1, ADDR_TX_HI, 8'h5e);
    `CHK("txf", 8'h5e, txf)
  endtask : t_write
  function automatic logic [3:0] nib(input logic [15:0] p, input int i);
    return (p[4*i+:4] == 4'hf) ? 4'h0 : p[4*i+:4];
  endfunction : nib
  task automatic t_tx(input logic s, input logic [15:0] p);
    int k;
    int n;
    int f;
    apb(1'b1, ADDR_SYNC_HI, p[15:8]);
    apb(1'b1, ADDR_SYNC_LO, p[7:0]);
    apb(1'b1, ADDR_TX_HI, {2'b10, s, 5'h01});
    `CHK("pattern", p, frame_sync_pattern)
    f = (s ? 12 : 8) * S + 1;
    k = 0;
    n = 0;
    transmit_on_strobe <= 1'b1;
    @(posedge pclk);
    transmit_on_strobe <= 1'b0;
    while (tx_sync_done !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
      if (k == 1) `CHK("busy", 1'b1, tx_busy)
      // A strobe while busy must not restart the frame
      transmit_on_strobe <= (k == 2);
      if (tx_sym_valid === 1'b1) begin
        `CHK("sym_at", f + n * S, k)
        `CHK("sym", nib(p, n), tx_sym)
        n++;
      end
    end
    `CHK("done_at", f + 4 * S, k)
    `CHK("sym_count", 4, n)
  endtask : t_tx
  task automatic t_rx(input logic [15:0] p, input logic [19:0] st, input logic e);
    apb(1'b1, ADDR_SYNC_HI, p[15:8]);
    apb(1'b1, ADDR_SYNC_LO, p[7:0]);
    for (int i = 4; i >= 0; i--) begin
      {rx_sym, rx_sym_valid} <= {st[4*i+:4], 1'b1};
      @(posedge pclk);
    end
    rx_sym_valid <= 1'b0;
    @(posedge pclk);
    `CHK("found", e, rx_sync_found)
  endtask : t_rx
  initial begin
    {pclk, presetn, psel, penable, pwrite, transmit_on_strobe, rx_sym_valid} = '0;
    {paddr, pwdata, rx_sym, pstrb} = {54'h0, 4'hf};
    {failures, checks_done, cycles} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_write();
    t_tx(1'b0, 16'hf5f1);
    t_tx(1'b1, 16'ha70f);
    t_rx(16'ha70f, 20'h1007a, 1'b1);
    t_rx(16'h3f21, 20'h01253, 1'b1);
    t_rx(16'h4321, 20'h91234, 1'b0);
    t_rx(16'h4321, 20'h01234, 1'b1);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
